// >>> rtl/l2dl_defs.svh
// Purpose: register map, field positions, reset values of the layer-2 destination lookup
// Assumes: byte addresses on a 16-bit plain register port, 32-bit data
// Notes: rules of the block follow
`ifndef L2DL_DEFS_SVH
`define L2DL_DEFS_SVH

// address fields
`define L2DL_SEL_HI      15
`define L2DL_SEL_LO      12
`define L2DL_IDX_HI      11
`define L2DL_IDX_LO      3
`define L2DL_WORD_BIT    2

// table selects
`define L2DL_TAB_CTRL    4'h0
`define L2DL_TAB_HKEY    4'h1
`define L2DL_TAB_HAGE    4'h2
`define L2DL_TAB_CKEY    4'h3
`define L2DL_TAB_CMASK   4'h4
`define L2DL_TAB_CAGE    4'h5
`define L2DL_TAB_DEST    4'h6
`define L2DL_TAB_MCAST   4'h7
`define L2DL_TAB_VLAN    4'h8

// control table indices
`define L2DL_CTRL_ENABLE 9'h000
`define L2DL_CTRL_DROPS  9'h001
`define L2DL_ENABLE_RST  1'b1

// aging word bits
`define L2DL_AGE_VALID   0
`define L2DL_AGE_SHADOW  1
`define L2DL_AGE_REPLICA 2
`define L2DL_AGE_HIT     3

// destination word bits
`define L2DL_DEST_DROP   9
`define L2DL_DEST_SINGLE 8
`define L2DL_DEST_PTR_HI 7

// vlan word: group at [27:16], members from bit 0
`define L2DL_VLAN_GID_LO 16

`define L2DL_BCAST_MAC   48'hffff_ffff_ffff

`endif

// >>> rtl/l2dl_pkg.sv
// Purpose: shared types of the layer-2 destination lookup
// Assumes: nothing beyond the header of constants
// Notes: result kind is one-hot so the far stage can test single bits
package l2dl_pkg;

   typedef enum logic [5:0] {
      L2DL_KIND_NONE  = 6'h00,
      L2DL_KIND_SKIP  = 6'h01,
      L2DL_KIND_UCAST = 6'h02,
      L2DL_KIND_MCAST = 6'h04,
      L2DL_KIND_FLOOD = 6'h08,
      L2DL_KIND_BCAST = 6'h10,
      L2DL_KIND_DROP  = 6'h20
   } l2dl_kind_e;

endpackage : l2dl_pkg

// >>> rtl/l2dl_key_cmp.sv
// Purpose: one masked key comparator, used for hash buckets and CAM entries
// Assumes: mask all ones for exact compare
// Notes: purely combinational
`timescale 1ns/10ps
module l2dl_key_cmp #(
   parameter int KW = 60
) (
   input  wire logic [KW-1:0] key,
   input  wire logic [KW-1:0] entry,
   input  wire logic [KW-1:0] mask,
   input  wire logic          valid,
   output logic               match
);

   assign match = valid && (((key ^ entry) & mask) == '0);

endmodule : l2dl_key_cmp

// >>> rtl/l2dl_lookup.sv
// Purpose: per-packet layer-2 destination lookup, result one cycle after request
// Assumes: request side and register port run on CLK_SYS; tables held in flip-flops
// Notes: tables are software loaded; the learning engine is not part of this block
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "l2dl_defs.svh"
module l2dl_lookup #(
   parameter int PORTS = 12,
   parameter int GW    = 12,
   parameter int HROWS = 16,
   parameter int BK    = 4,
   parameter int CN    = 8,
   parameter int MN    = 16,
   parameter int VN    = 16
) (
   input  wire logic                   CLK_SYS,
   input  wire logic                   ARST_N,
   input  wire logic [15:0]            ADDR,
   input  wire logic [31:0]            WR_DATA,
   input  wire logic                   WR_STB,
   input  wire logic                   RD_STB,
   output logic      [31:0]            RD_DATA,
   input  wire logic                   REQ_VALID,
   input  wire logic [$clog2(VN)-1:0]  REQ_VLAN_IDX,
   input  wire logic [47:0]            REQ_DEST_MAC,
   input  wire logic [3:0]             REQ_SRC_PORT,
   input  wire logic                   REQ_TO_CPU,
   input  wire logic                   REQ_CLASS_ACT,
   input  wire logic                   REQ_FROM_CPU,
   input  wire logic                   REQ_ROUTED,
   input  wire logic                   REQ_DROPPED,
   output logic                        RES_VALID,
   output logic [PORTS-1:0]            RES_PORTS,
   output logic [5:0]                  RES_KIND,
   output logic                        RES_HIT
);

   localparam int KW  = GW + 48;
   localparam int IW  = $clog2(HROWS);
   localparam int HN  = HROWS * BK;
   localparam int DN  = HN + CN;
   localparam int DEW = `L2DL_DEST_DROP + 1;
   localparam int VW  = `L2DL_VLAN_GID_LO + GW;

   typedef struct packed {
      logic [HN-1:0][KW-1:0]    hkey;
      logic [HN-1:0][3:0]       hage;
      logic [CN-1:0][KW-1:0]    ckey;
      logic [CN-1:0][KW-1:0]    cmask;
      logic [CN-1:0][3:0]       cage;
      logic [DN-1:0][DEW-1:0]   dest;
      logic [MN-1:0][PORTS-1:0] mc;
      logic [VN-1:0][VW-1:0]    vlan;
      logic                     en;
      logic [31:0]              drops;
      logic [31:0]              rdata;
      logic                     res_valid;
      logic [PORTS-1:0]         res_ports;
      logic [5:0]               res_kind;
      logic                     res_hit;
   } l2dl_state_s;

   l2dl_state_s st;
   l2dl_state_s next_st;

   logic [3:0]            sel;
   logic [8:0]            ix;
   logic                  wd;
   logic [GW-1:0]         gid;
   logic [PORTS-1:0]      members;
   logic [KW-1:0]         key;
   logic [IW-1:0]         row;
   logic [BK-1:0]         bmatch;
   logic [CN-1:0]         cmatch;
   logic                  hhit;
   logic                  chit;
   logic [$clog2(BK)-1:0] bsel;
   logic [$clog2(CN)-1:0] csel;
   logic [$clog2(HN)-1:0] hidx;
   logic [$clog2(DN)-1:0] didx;
   logic [DEW-1:0]        dent;
   logic                  skip;
   logic                  bcast;
   logic [PORTS-1:0]      src_bit;
   logic [PORTS-1:0]      one_port;
   logic [PORTS-1:0]      mask;
   logic [5:0]            kind;
   logic                  lookup;

   assign sel = ADDR[`L2DL_SEL_HI:`L2DL_SEL_LO];
   assign ix  = ADDR[`L2DL_IDX_HI:`L2DL_IDX_LO];
   assign wd  = ADDR[`L2DL_WORD_BIT];

   // xor fold; spreads all key bits over the row index
   function automatic logic [IW-1:0] hash_key(input logic [KW-1:0] k);
      logic [IW-1:0] h;
      h = '0;
      for (int i = 0; i < KW; i++) begin
         h[i % IW] = h[i % IW] ^ k[i];
      end
      return h;
   endfunction : hash_key

   assign gid     = st.vlan[REQ_VLAN_IDX][VW-1:`L2DL_VLAN_GID_LO];
   assign members = st.vlan[REQ_VLAN_IDX][PORTS-1:0];
   assign key     = {gid, REQ_DEST_MAC};
   assign row     = hash_key(key);

   genvar g;
   generate
      for (g = 0; g < BK; g++) begin : g_bucket
         l2dl_key_cmp #(
            .KW (KW)
         ) u_cmp (
            .key   (key),
            .entry (st.hkey[row * BK + g]),
            .mask  ({KW{1'b1}}),
            .valid (st.hage[row * BK + g][`L2DL_AGE_VALID] &
                    st.hage[row * BK + g][`L2DL_AGE_SHADOW] &
                    st.hage[row * BK + g][`L2DL_AGE_REPLICA]),
            .match (bmatch[g])
         );
      end
      for (g = 0; g < CN; g++) begin : g_cam
         l2dl_key_cmp #(
            .KW (KW)
         ) u_cmp (
            .key   (key),
            .entry (st.ckey[g]),
            .mask  (st.cmask[g]),
            .valid (st.cage[g][`L2DL_AGE_VALID] &
                    st.cage[g][`L2DL_AGE_SHADOW]),
            .match (cmatch[g])
         );
      end
   endgenerate

   // priority pick and result resolution
   always_comb begin
      bsel = '0;
      for (int b = BK - 1; b >= 0; b--) begin
         if (bmatch[b]) begin
            bsel = b[$clog2(BK)-1:0];
         end
      end
      csel = '0;
      for (int c = CN - 1; c >= 0; c--) begin
         if (cmatch[c]) begin
            csel = c[$clog2(CN)-1:0];
         end
      end
      hhit = |bmatch;
      chit = |cmatch;
      hidx = $clog2(HN)'({row, bsel});
      if (chit) begin
         didx = $clog2(DN)'(HN + 32'(csel));
      end else begin
         didx = $clog2(DN)'(hidx);
      end
      dent    = st.dest[didx];
      src_bit = '0;
      for (int p = 0; p < PORTS; p++) begin
         src_bit[p] = (REQ_SRC_PORT == 4'(p));
      end
      one_port = '0;
      for (int p = 0; p < PORTS; p++) begin
         one_port[p] = (dent[`L2DL_DEST_PTR_HI:0] == 8'(p));
      end
      skip  = REQ_TO_CPU | REQ_CLASS_ACT | REQ_FROM_CPU |
              REQ_ROUTED | REQ_DROPPED | ~st.en;
      bcast = (REQ_DEST_MAC == `L2DL_BCAST_MAC);
      mask  = '0;
      kind  = l2dl_pkg::L2DL_KIND_NONE;
      if (skip) begin
         kind = l2dl_pkg::L2DL_KIND_SKIP;
      end else if (bcast) begin
         mask = members & ~src_bit;
         kind = l2dl_pkg::L2DL_KIND_BCAST;
      end else if (!(hhit || chit)) begin
         mask = members & ~src_bit;
         kind = l2dl_pkg::L2DL_KIND_FLOOD;
      end else if (dent[`L2DL_DEST_DROP]) begin
         kind = l2dl_pkg::L2DL_KIND_DROP;
      end else if (dent[`L2DL_DEST_SINGLE]) begin
         mask = one_port & members;
         kind = l2dl_pkg::L2DL_KIND_UCAST;
      end else begin
         mask = st.mc[dent[$clog2(MN)-1:0]] & ~src_bit & members;
         kind = l2dl_pkg::L2DL_KIND_MCAST;
      end
      mask = mask & members;
      if (!skip && mask == '0) begin
         kind = l2dl_pkg::L2DL_KIND_DROP;
      end
      lookup = REQ_VALID && !skip;
   end

   // register port and state update
   always_comb begin
      next_st = st;
      // software writes first so hardware set of a hit bit wins below
      if (WR_STB) begin
         unique case (sel)
            `L2DL_TAB_CTRL: begin
               if (ix == `L2DL_CTRL_ENABLE) begin
                  next_st.en = WR_DATA[0];
               end
            end
            `L2DL_TAB_HKEY: begin
               if (ix < HN && !wd) begin
                  next_st.hkey[ix][31:0] = WR_DATA;
               end else if (ix < HN) begin
                  next_st.hkey[ix][KW-1:32] = WR_DATA[KW-33:0];
               end
            end
            `L2DL_TAB_HAGE: begin
               if (ix < HN) begin
                  next_st.hage[ix] = WR_DATA[3:0];
               end
            end
            `L2DL_TAB_CKEY: begin
               if (ix < CN && !wd) begin
                  next_st.ckey[ix][31:0] = WR_DATA;
               end else if (ix < CN) begin
                  next_st.ckey[ix][KW-1:32] = WR_DATA[KW-33:0];
               end
            end
            `L2DL_TAB_CMASK: begin
               if (ix < CN && !wd) begin
                  next_st.cmask[ix][31:0] = WR_DATA;
               end else if (ix < CN) begin
                  next_st.cmask[ix][KW-1:32] = WR_DATA[KW-33:0];
               end
            end
            `L2DL_TAB_CAGE: begin
               if (ix < CN) begin
                  next_st.cage[ix] = WR_DATA[3:0];
               end
            end
            `L2DL_TAB_DEST: begin
               if (ix < DN) begin
                  next_st.dest[ix] = WR_DATA[DEW-1:0];
               end
            end
            `L2DL_TAB_MCAST: begin
               if (ix < MN) begin
                  next_st.mc[ix] = WR_DATA[PORTS-1:0];
               end
            end
            `L2DL_TAB_VLAN: begin
               if (ix < VN) begin
                  next_st.vlan[ix] = WR_DATA[VW-1:0];
               end
            end
            default: begin
            end
         endcase
      end
      next_st.rdata = '0;
      if (RD_STB) begin
         unique case (sel)
            `L2DL_TAB_CTRL: begin
               if (ix == `L2DL_CTRL_ENABLE) begin
                  next_st.rdata = {31'h0, st.en};
               end else if (ix == `L2DL_CTRL_DROPS) begin
                  next_st.rdata = st.drops;
               end
            end
            `L2DL_TAB_HKEY: begin
               if (ix < HN) begin
                  next_st.rdata = wd ? 32'(st.hkey[ix][KW-1:32]) : st.hkey[ix][31:0];
               end
            end
            `L2DL_TAB_HAGE: begin
               if (ix < HN) begin
                  next_st.rdata = 32'(st.hage[ix]);
               end
            end
            `L2DL_TAB_CKEY: begin
               if (ix < CN) begin
                  next_st.rdata = wd ? 32'(st.ckey[ix][KW-1:32]) : st.ckey[ix][31:0];
               end
            end
            `L2DL_TAB_CMASK: begin
               if (ix < CN) begin
                  next_st.rdata = wd ? 32'(st.cmask[ix][KW-1:32]) : st.cmask[ix][31:0];
               end
            end
            `L2DL_TAB_CAGE: begin
               if (ix < CN) begin
                  next_st.rdata = 32'(st.cage[ix]);
               end
            end
            `L2DL_TAB_DEST: begin
               if (ix < DN) begin
                  next_st.rdata = 32'(st.dest[ix]);
               end
            end
            `L2DL_TAB_MCAST: begin
               if (ix < MN) begin
                  next_st.rdata = 32'(st.mc[ix]);
               end
            end
            `L2DL_TAB_VLAN: begin
               if (ix < VN) begin
                  next_st.rdata = 32'(st.vlan[ix]);
               end
            end
            default: begin
            end
         endcase
      end
      // hit bits: a software write in the same cycle cannot erase the set
      if (lookup && !bcast && chit) begin
         next_st.cage[csel][`L2DL_AGE_HIT] = 1'b1;
      end else if (lookup && !bcast && hhit) begin
         next_st.hage[hidx][`L2DL_AGE_HIT] = 1'b1;
      end
      // dent is stale on a miss or broadcast, so its drop flag only excuses a real hit
      if (lookup && mask == '0 && (bcast || !(hhit || chit) || !dent[`L2DL_DEST_DROP])) begin
         next_st.drops = st.drops + 32'h1;
      end
      next_st.res_valid = REQ_VALID;
      next_st.res_ports = REQ_VALID ? mask : '0;
      next_st.res_kind  = REQ_VALID ? kind : 6'h00;
      next_st.res_hit   = lookup && !bcast && (hhit || chit);
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         st    <= '0;
         st.en <= `L2DL_ENABLE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign RD_DATA   = st.rdata;
   assign RES_VALID = st.res_valid;
   assign RES_PORTS = st.res_ports;
   assign RES_KIND  = st.res_kind;
   assign RES_HIT   = st.res_hit;

endmodule : l2dl_lookup

// >>> test/l2dl_lookup_asserts.sv
// Purpose: port checks of the destination lookup
// Assumes: answer one cycle after each request
// Notes: bound into every l2dl_lookup
`timescale 1ns/10ps
module l2dl_lookup_asserts #(parameter int PORTS = 12) (
   input wire logic             CLK_SYS,
   input wire logic             ARST_N,
   input wire logic             REQ_VALID,
   input wire logic [47:0]      REQ_DEST_MAC,
   input wire logic [3:0]       REQ_SRC_PORT,
   input wire logic             REQ_TO_CPU,
   input wire logic             REQ_CLASS_ACT,
   input wire logic             REQ_FROM_CPU,
   input wire logic             REQ_ROUTED,
   input wire logic             REQ_DROPPED,
   input wire logic             RES_VALID,
   input wire logic [PORTS-1:0] RES_PORTS,
   input wire logic [5:0]       RES_KIND,
   input wire logic             RES_HIT
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);
   logic       skip;
   logic [3:0] src_q;
   assign skip = REQ_TO_CPU | REQ_CLASS_ACT | REQ_FROM_CPU | REQ_ROUTED | REQ_DROPPED;
   // source of the request being answered now
   always_ff @(posedge CLK_SYS or negedge ARST_N)
      if (!ARST_N)
         src_q <= 4'h0;
      else
         src_q <= REQ_SRC_PORT;
   sequence s_bcast;
      REQ_VALID && !skip && REQ_DEST_MAC == 48'hffff_ffff_ffff;
   endsequence
   sequence s_spread;
      RES_VALID && src_q < PORTS && RES_KIND inside {l2dl_pkg::L2DL_KIND_MCAST,
         l2dl_pkg::L2DL_KIND_FLOOD, l2dl_pkg::L2DL_KIND_BCAST};
   endsequence
   a_answer_next: assert property (REQ_VALID |=> RES_VALID)
      else $error("request not answered");
   a_no_stray: assert property (RES_VALID |-> $past(REQ_VALID))
      else $error("answer without request");
   a_kind_onehot: assert property (RES_VALID |-> $onehot(RES_KIND))
      else $error("kind not one-hot");
   a_skip_kind: assert property (
      REQ_VALID && skip |=> RES_KIND == l2dl_pkg::L2DL_KIND_SKIP && RES_PORTS == '0)
      else $error("skip flag ignored");
   a_bcast_kind: assert property (s_bcast |=> !RES_HIT && RES_KIND inside
      {l2dl_pkg::L2DL_KIND_BCAST, l2dl_pkg::L2DL_KIND_DROP, l2dl_pkg::L2DL_KIND_SKIP})
      else $error("broadcast looked up");
   a_src_excl: assert property (s_spread |-> !RES_PORTS[src_q])
      else $error("source port kept");
   a_drop_empty: assert property (
      RES_KIND == l2dl_pkg::L2DL_KIND_DROP |-> RES_PORTS == '0)
      else $error("drop with ports");
   a_empty_drops: assert property (RES_VALID && RES_PORTS == '0 |-> RES_KIND inside
      {l2dl_pkg::L2DL_KIND_DROP, l2dl_pkg::L2DL_KIND_SKIP})
      else $error("empty mask forwarded");
   a_ucast_one: assert property (
      RES_KIND == l2dl_pkg::L2DL_KIND_UCAST |-> $onehot(RES_PORTS) && RES_HIT)
      else $error("bad unicast");
   a_flood_miss: assert property (
      RES_KIND == l2dl_pkg::L2DL_KIND_FLOOD |-> !RES_HIT)
      else $error("flood on a hit");
endmodule : l2dl_lookup_asserts

bind l2dl_lookup l2dl_lookup_asserts #(.PORTS(PORTS)) u_asserts (
   .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .REQ_VALID(REQ_VALID), .REQ_DEST_MAC(REQ_DEST_MAC),
   .REQ_SRC_PORT(REQ_SRC_PORT), .REQ_TO_CPU(REQ_TO_CPU), .REQ_CLASS_ACT(REQ_CLASS_ACT),
   .REQ_FROM_CPU(REQ_FROM_CPU), .REQ_ROUTED(REQ_ROUTED), .REQ_DROPPED(REQ_DROPPED),
   .RES_VALID(RES_VALID), .RES_PORTS(RES_PORTS), .RES_KIND(RES_KIND), .RES_HIT(RES_HIT));

// >>> test/l2dl_lag_model.sv
// Purpose: stand-in for the link aggregation stage
// Assumes: results come as one-cycle pulses
// Notes: no group hashing, the lowest port is taken
`timescale 1ns/10ps
module l2dl_lag_model #(parameter int PORTS = 12) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             res_valid,
   input  wire logic [PORTS-1:0] res_ports,
   output logic      [3:0]       phys_port,
   output int                    n_taken
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phys_port <= 4'h0;
         n_taken   <= 0;
      end else if (res_valid && res_ports != '0) begin
         n_taken <= n_taken + 1;
         for (int i = PORTS - 1; i >= 0; i--)
            if (res_ports[i])
               phys_port <= 4'(i);
      end
   end
endmodule : l2dl_lag_model

// >>> test/tb.sv
// Purpose: self-checking bench of the destination lookup
// Assumes: default sizes, group 12 bits
// Notes: drivers queue expectations, a watcher compares
`timescale 1ns/10ps
module tb;
   localparam logic [11:0] G = 12'h5a3;
   logic        clk = 0, rst_n = 0, ws = 0, rs = 0, rv = 0, rd_pend = 0;
   logic [15:0] addr = 0;
   logic [31:0] wd = 0;
   logic [31:0] lq[$], rq[$];
   logic [47:0] mac = 0;
   logic [3:0]  vi = 0, src = 0;
   logic [4:0]  fl = 0;
   wire  [31:0] rdd;
   wire  [11:0] op;
   wire  [5:0]  ok;
   wire         ov, oh;
   int          bad_count = 0, n_checks = 0, nfwd = 0, lag_n;
   always #20 clk = ~clk;
   l2dl_lookup dut (
      .CLK_SYS(clk), .ARST_N(rst_n), .ADDR(addr), .WR_DATA(wd), .WR_STB(ws), .RD_STB(rs),
      .RD_DATA(rdd), .REQ_VALID(rv), .REQ_VLAN_IDX(vi), .REQ_DEST_MAC(mac),
      .REQ_SRC_PORT(src), .REQ_TO_CPU(fl[0]), .REQ_CLASS_ACT(fl[1]), .REQ_FROM_CPU(fl[2]),
      .REQ_ROUTED(fl[3]), .REQ_DROPPED(fl[4]), .RES_VALID(ov), .RES_PORTS(op),
      .RES_KIND(ok), .RES_HIT(oh));
   l2dl_lag_model lag (.clk(clk), .rst_n(rst_n), .res_valid(ov), .res_ports(op),
      .phys_port(), .n_taken(lag_n));
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   function automatic logic [3:0] hrow(input logic [59:0] k);
      hrow = 4'h0;
      for (int j = 0; j < 60; j++)
         hrow[j % 4] ^= k[j];
   endfunction : hrow
   function automatic logic [47:0] mm(input logic [3:0] n);
      mm = {44'h020_0000_0000, n};
   endfunction : mm
   // a read queues its expected data in d
   task automatic rg(logic w, logic [3:0] s, logic [8:0] i, logic b, logic [31:0] d);
      @(posedge clk);
      ws <= w;
      rs <= !w;
      rv <= 1'b0;
      addr <= {s, i, b, 2'b00};
      wd <= w ? d : 32'h0;
      if (!w)
         rq.push_back(d);
   endtask : rg
   task automatic lk(logic [3:0] v, s, logic [47:0] m, logic [4:0] f, logic h,
                     logic [5:0] k, logic [11:0] p);
      @(posedge clk);
      ws <= 1'b0;
      rs <= 1'b0;
      rv <= 1'b1;
      vi <= v;
      src <= s;
      mac <= m;
      fl <= f;
      lq.push_back({13'h0, h, k, p});
      if (p != 0)
         nfwd++;
   endtask : lk
   task automatic sh(logic [59:0] k, int b, logic [3:0] a, logic [9:0] d);
      logic [8:0] i;
      i = 9'(hrow(k) * 4 + b);
      rg(1, 4'h1, i, 0, k[31:0]);
      rg(1, 4'h1, i, 1, 32'(k[59:32]));
      rg(1, 4'h2, i, 0, 32'(a));
      rg(1, 4'h6, i, 0, 32'(d));
   endtask : sh
   task automatic sc(logic [8:0] i, logic [59:0] k, m, logic [3:0] a, logic [9:0] d);
      rg(1, 4'h3, i, 0, k[31:0]);
      rg(1, 4'h3, i, 1, 32'(k[59:32]));
      rg(1, 4'h4, i, 0, m[31:0]);
      rg(1, 4'h4, i, 1, 32'(m[59:32]));
      rg(1, 4'h5, i, 0, 32'(a));
      rg(1, 4'h6, i + 9'd64, 0, 32'(d));
   endtask : sc
   always @(posedge clk)
      rd_pend <= rs;
   always @(negedge clk) begin
      if (ov === 1'b1)
         chk("result", {13'h0, oh, ok, op}, lq.size() > 0 ? lq.pop_front() : 32'hx);
      if (rd_pend)
         chk("rd_data", rdd, rq.size() > 0 ? rq.pop_front() : 32'hx);
   end
   initial begin
      #400000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      logic [47:0] m;
      logic [3:0]  s;
      logic [4:0]  f;
      void'($urandom(11678));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rg(0, 4'h0, 9'h000, 0, 32'h1);
      rg(1, 4'h0, 9'h001, 0, 32'h5);
      rg(0, 4'h0, 9'h001, 0, 32'h0);
      rg(0, 4'hf, 9'h000, 0, 32'h0);
      // tables are loaded only while no learning engine runs
      rg(1, 4'h8, 9'h001, 0, 32'h05a3_00f7);
      rg(1, 4'h8, 9'h003, 0, 32'h00a0_0200);
      rg(1, 4'h8, 9'h002, 0, 32'h00a0_0f00);
      rg(1, 4'h7, 9'h003, 0, 32'h0000_00ff);
      sh({G, mm(1)}, 2, 4'h7, 10'h105);
      sh({G, mm(2)}, 1, 4'h3, 10'h101);
      sh({G, mm(3)}, 0, 4'h7, 10'h104);
      sh({G, mm(3)}, 1, 4'h7, 10'h106);
      sh({G, mm(4)}, 3, 4'h7, 10'h101);
      sc(9'd2, {G, mm(4)} ^ 60'h50, ~60'hf0, 4'h3, 10'h003);
      sc(9'd5, {G, mm(4)}, '1, 4'h3, 10'h200);
      sc(9'd6, {G, mm(5)}, '1, 4'h1, 10'h101);
      sh({G, mm(6)}, 0, 4'h7, 10'h305);
      sh({G, mm(7)}, 0, 4'h7, 10'h103);
      lk(1, 5, mm(1), 0, 1, l2dl_pkg::L2DL_KIND_UCAST, 12'h020);
      lk(1, 0, mm(2), 0, 0, l2dl_pkg::L2DL_KIND_FLOOD, 12'h0f6);
      lk(1, 2, mm(3), 0, 1, l2dl_pkg::L2DL_KIND_UCAST, 12'h010);
      lk(1, 1, mm(4), 0, 1, l2dl_pkg::L2DL_KIND_MCAST, 12'h0f5);
      lk(1, 7, mm(5), 0, 0, l2dl_pkg::L2DL_KIND_FLOOD, 12'h077);
      lk(1, 0, mm(6), 0, 1, l2dl_pkg::L2DL_KIND_DROP, 12'h000);
      lk(1, 0, mm(7), 0, 1, l2dl_pkg::L2DL_KIND_DROP, 12'h000);
      lk(1, 4, '1, 0, 0, l2dl_pkg::L2DL_KIND_BCAST, 12'h0e7);
      lk(2, 9, mm(1), 0, 0, l2dl_pkg::L2DL_KIND_FLOOD, 12'hd00);
      // miss on the row of a drop-flagged entry: empty flood must still count
      lk(3, 9, mm(0), 0, 0, l2dl_pkg::L2DL_KIND_DROP, 12'h000);
      rg(0, 4'h2, 9'(hrow({G, mm(1)}) * 4 + 2), 0, 32'hf);
      rg(0, 4'h2, 9'(hrow({G, mm(2)}) * 4 + 1), 0, 32'h3);
      rg(0, 4'h5, 9'd2, 0, 32'hb);
      rg(0, 4'h0, 9'h001, 0, 32'h2);
      for (int i = 0; i < 5; i++)
         lk(1, 5, mm(1), 5'(1 << i), 0, l2dl_pkg::L2DL_KIND_SKIP, 12'h0);
      rg(1, 4'h0, 9'h000, 0, 32'h0);
      lk(1, 5, mm(1), 0, 0, l2dl_pkg::L2DL_KIND_SKIP, 12'h0);
      rg(1, 4'h0, 9'h000, 0, 32'h1);
      repeat (40) begin
         m = 48'({$urandom, $urandom});
         s = 4'($urandom % 12);
         f = 5'($urandom & $urandom & $urandom);
         lk(1, s, m, f, 0, f != 0 ? l2dl_pkg::L2DL_KIND_SKIP : l2dl_pkg::L2DL_KIND_FLOOD,
            f != 0 ? 12'h0 : 12'h0f7 & ~(12'h1 << s));
      end
      rg(0, 4'h0, 9'h001, 0, 32'h2);
      @(posedge clk);
      rs <= 1'b0;
      repeat (3) @(posedge clk);
      chk("forwarded", 32'(lag_n), 32'(nfwd));
      chk("pending", 32'(lq.size() + rq.size()), 32'h0);
      tally_and_finish();
   end
endmodule : tb
